//--- rtl/emp_pkg.sv
// Constants of the external memory port controller: register offsets, field layouts and reset values.
// Assumes a 16-bit I/O address space on the core side and a core clock of 250 MHz.
package emp_pkg;

  // ==========================================================================
  // Register offsets in the core's I/O space.
  localparam logic [15:0] EMP_OFS_PROG_WORD_HIGH_HALF  = 16'hFFF2;
  localparam logic [15:0] EMP_OFS_PROG_WORD_LOW_HALF   = 16'hFFF3;
  localparam logic [15:0] EMP_OFS_PROG_WORD_FULL       = 16'hFFF4;
  localparam logic [15:0] EMP_OFS_EXT_BUS_WAIT_CONTROL = 16'hFFFC;

  // ==========================================================================
  // Field layouts and reset values.
  localparam int          EMP_WAIT_LSB       = 0;
  localparam int          EMP_WAIT_W         = 5;
  localparam logic [4:0]  EMP_WAIT_RESET     = 5'h1F;
  localparam int          EMP_WORD_W         = 24;
  localparam int          EMP_HALF_W         = 16;
  localparam int          EMP_HIGH_W         = 8;
  localparam int          EMP_ADDR_W         = 16;
  localparam logic [23:0] EMP_HOLD_RESET     = 24'h000000;
  localparam logic [15:0] EMP_ADDR_RESET     = 16'hFFFF;

  // ==========================================================================
  // Wait-state thresholds for the trailing wait states and write strobe delay.
  localparam logic [4:0]  EMP_TRAIL1_MIN     = 5'h04;
  localparam logic [4:0]  EMP_TRAIL2_MIN     = 5'h08;
  localparam logic [4:0]  EMP_WR_HALF_MIN    = 5'h02;
  localparam logic [4:0]  EMP_WR_FULL_MIN    = 5'h04;

  // ==========================================================================
  // Timing: one clock_out period spans two core clocks.
  localparam int          EMP_CORE_CLK_NS    = 4;
  localparam int          EMP_CLOCK_OUT_NS      = 8;
  localparam int          EMP_HALF_CYCLES    = (EMP_CLOCK_OUT_NS / 2 + EMP_CORE_CLK_NS - 1) / EMP_CORE_CLK_NS;
  localparam int          EMP_PHASE_W        = 7;

  // ==========================================================================
  // Access sequencer states, Gray coded along the usual path.
  typedef enum logic [1:0]
  {
    EMP_IDLE = 2'b00,
    EMP_RUN  = 2'b01,
    EMP_DONE = 2'b11
  } emp_state_e;

endpackage : emp_pkg

//--- rtl/emp_wait_timer.sv
// Half-cycle timer of one external access: counts clock_out half cycles and marks the access phases.
// Assumes a start pulse only while idle and a stable wait-state count during the access.
`timescale 1ns/1ps
module emp_wait_timer
  import emp_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_start,
  input  wire logic       i_abort,
  input  wire logic [4:0] i_wait_states,
  output logic            o_active,
  output logic            o_rd_window,
  output logic            o_wr_window,
  output logic            o_sample,
  output logic            o_last
);
  import emp_pkg::*;

  logic [EMP_PHASE_W-1:0] phase;
  logic [EMP_PHASE_W-1:0] next_phase;
  logic                   run;
  logic                   next_run;
  logic [EMP_PHASE_W-1:0] main_end;
  logic [EMP_PHASE_W-1:0] total;
  logic [EMP_PHASE_W-1:0] wr_start;
  logic [1:0]             trail;

  // ==========================================================================
  // Phase boundaries, in half cycles of clock_out.
  always_comb
  begin
    if (i_wait_states >= EMP_TRAIL2_MIN)
      trail = 2'd2;
    else if (i_wait_states >= EMP_TRAIL1_MIN)
      trail = 2'd1;
    else
      trail = 2'd0;
    if (i_wait_states >= EMP_WR_FULL_MIN)
      wr_start = EMP_PHASE_W'(1 + 2 * EMP_HALF_CYCLES);
    else if (i_wait_states >= EMP_WR_HALF_MIN)
      wr_start = EMP_PHASE_W'(1 + EMP_HALF_CYCLES);
    else
      wr_start = EMP_PHASE_W'(1);
    // Setup cycle plus the programmed wait states; sampling ends here.
    main_end = EMP_PHASE_W'(2 * (1 + i_wait_states));
    // Trailing states lengthen only the hold and release time.
    total    = main_end + EMP_PHASE_W'(2 * trail);
  end

  // ==========================================================================
  // Counter.
  always_comb
  begin
    next_run   = run;
    next_phase = phase;
    if (i_abort)
    begin
      next_run   = 1'b0;
      next_phase = '0;
    end
    else if (i_start && !run)
    begin
      next_run   = 1'b1;
      next_phase = '0;
    end
    else if (run)
    begin
      if (phase == total - EMP_PHASE_W'(1))
      begin
        next_run   = 1'b0;
        next_phase = '0;
      end
      else
        next_phase = phase + EMP_PHASE_W'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      run   <= 1'b0;
      phase <= '0;
    end
    else
    begin
      run   <= next_run;
      phase <= next_phase;
    end
  end

  assign o_active    = run;
  assign o_rd_window = run && (phase >= EMP_PHASE_W'(1)) && (phase < main_end);
  assign o_wr_window = run && (phase >= wr_start) && (phase < main_end);
  assign o_sample    = run && (phase == main_end - EMP_PHASE_W'(1));
  assign o_last      = run && (phase == total - EMP_PHASE_W'(1));

endmodule : emp_wait_timer

//--- rtl/emp_port_ctrl.sv
// External memory port controller: wait-state control register, program-word holding register
// and the access sequencer that drives the static memory pins.
// Assumes the operating mode register lives in the core and supplies the disable level, and that
// the core issues one external request at a time and waits for o_ext_done.
`timescale 1ns/1ps
module emp_port_ctrl
  import emp_pkg::*;
(
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst_b,
  // Disable level from the operating mode register.
  input  wire logic                       i_ext_bus_disable,
  // Core I/O register port.
  input  wire logic [emp_pkg::EMP_ADDR_W-1:0] i_io_addr,
  input  wire logic                       i_io_wr,
  input  wire logic                       i_io_rd,
  input  wire logic                       i_io_wide,
  input  wire logic [emp_pkg::EMP_WORD_W-1:0] i_io_wdata,
  output logic      [emp_pkg::EMP_WORD_W-1:0] o_io_rdata,
  // Core external access request.
  input  wire logic                       i_ext_req,
  input  wire logic                       i_ext_we,
  input  wire logic [emp_pkg::EMP_ADDR_W-1:0] i_ext_addr,
  input  wire logic [emp_pkg::EMP_WORD_W-1:0] i_ext_wdata,
  output logic                            o_ext_busy,
  output logic                            o_ext_done,
  output logic      [emp_pkg::EMP_WORD_W-1:0] o_ext_rdata,
  // Static memory pins.
  output logic                            o_clock_out,
  output logic      [emp_pkg::EMP_ADDR_W-1:0] o_addr,
  output logic      [emp_pkg::EMP_WORD_W-1:0] o_data_out,
  output logic                            o_data_oe,
  input  wire logic [emp_pkg::EMP_WORD_W-1:0] i_data_in,
  output logic                            o_memory_chip_select_n,
  output logic                            o_rd_n,
  output logic                            o_wr_n
);
  import emp_pkg::*;

  // ==========================================================================
  // Register file.
  logic [EMP_WAIT_W-1:0] wait_state_count;
  logic [EMP_WAIT_W-1:0] next_wait_state_count;
  logic [EMP_WORD_W-1:0] prog_word_holding;
  logic [EMP_WORD_W-1:0] next_prog_word_holding;
  logic [EMP_WORD_W-1:0] io_rdata;
  logic [EMP_WORD_W-1:0] next_io_rdata;

  always_comb
  begin
    next_wait_state_count  = wait_state_count;
    next_prog_word_holding = prog_word_holding;
    if (i_io_wr)
    begin
      unique case (i_io_addr)
        EMP_OFS_EXT_BUS_WAIT_CONTROL:
          next_wait_state_count = i_io_wdata[EMP_WAIT_LSB +: EMP_WAIT_W];
        EMP_OFS_PROG_WORD_LOW_HALF:
          next_prog_word_holding[EMP_HALF_W-1:0] = i_io_wdata[EMP_HALF_W-1:0];
        EMP_OFS_PROG_WORD_HIGH_HALF:
          next_prog_word_holding[EMP_WORD_W-1:EMP_HALF_W] =
            i_io_wdata[EMP_HIGH_W-1:0];
        EMP_OFS_PROG_WORD_FULL:
          if (i_io_wide)
            next_prog_word_holding = i_io_wdata;
          else
            next_prog_word_holding[EMP_HALF_W-1:0] = i_io_wdata[EMP_HALF_W-1:0];
        default:
          next_prog_word_holding = prog_word_holding;
      endcase
    end
  end

  always_comb
  begin
    next_io_rdata = '0;
    if (i_io_rd)
    begin
      unique case (i_io_addr)
        EMP_OFS_EXT_BUS_WAIT_CONTROL:
          next_io_rdata = {{(EMP_WORD_W - EMP_WAIT_W){1'b0}}, wait_state_count};
        EMP_OFS_PROG_WORD_LOW_HALF:
          next_io_rdata = {{EMP_HIGH_W{1'b0}}, prog_word_holding[EMP_HALF_W-1:0]};
        EMP_OFS_PROG_WORD_HIGH_HALF:
          next_io_rdata = {{EMP_HALF_W{1'b0}}, prog_word_holding[EMP_WORD_W-1:EMP_HALF_W]};
        EMP_OFS_PROG_WORD_FULL:
          if (i_io_wide)
            next_io_rdata = prog_word_holding;
          else
            next_io_rdata = {{EMP_HIGH_W{1'b0}}, prog_word_holding[EMP_HALF_W-1:0]};
        default:
          next_io_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wait_state_count  <= EMP_WAIT_RESET;
      prog_word_holding <= EMP_HOLD_RESET;
      io_rdata          <= '0;
    end
    else
    begin
      wait_state_count  <= next_wait_state_count;
      prog_word_holding <= next_prog_word_holding;
      io_rdata          <= next_io_rdata;
    end
  end

  assign o_io_rdata = io_rdata;

  // ==========================================================================
  // Clock out: a 50% duty clock at half the core rate.
  logic clock_out;
  logic next_clock_out;

  always_comb
  begin
    next_clock_out = ~clock_out;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      clock_out <= 1'b1;
    else
      clock_out <= next_clock_out;
  end

  assign o_clock_out = clock_out;

  // ==========================================================================
  // Data input register.
  // The memory answers the registered strobes of this block, so its data settles well ahead of
  // the sample point; a three-stage synchroniser would cost more cycles than a one-wait-state
  // access leaves before the sample point.
  logic [EMP_WORD_W-1:0] din_q;
  logic [EMP_WORD_W-1:0] next_din_q;

  always_comb
  begin
    next_din_q = i_data_in;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      din_q <= '0;
    else
      din_q <= next_din_q;
  end

  // ==========================================================================
  // Access sequencer.
  emp_state_e            state;
  emp_state_e            next_state;
  logic                  we;
  logic                  next_we;
  logic [EMP_ADDR_W-1:0] addr;
  logic [EMP_ADDR_W-1:0] next_addr;
  logic [EMP_WORD_W-1:0] wdata;
  logic [EMP_WORD_W-1:0] next_wdata;
  logic [EMP_WORD_W-1:0] rdata;
  logic [EMP_WORD_W-1:0] next_rdata;
  logic                  start;
  logic                  t_active;
  logic                  t_rd;
  logic                  t_wr;
  logic                  t_sample;
  logic                  t_last;

  // A disabled port ignores requests and aborts any access in flight.
  assign start = (state == EMP_IDLE) && i_ext_req && !i_ext_bus_disable;

  emp_wait_timer u_timer
  (
    .i_core_clk    (i_core_clk),
    .i_rst_b       (i_rst_b),
    .i_start       (start),
    .i_abort       (i_ext_bus_disable),
    .i_wait_states (wait_state_count),
    .o_active      (t_active),
    .o_rd_window   (t_rd),
    .o_wr_window   (t_wr),
    .o_sample      (t_sample),
    .o_last        (t_last)
  );

  always_comb
  begin
    next_state = state;
    next_we    = we;
    next_addr  = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    unique case (state)
      EMP_IDLE:
        if (start)
        begin
          next_state = EMP_RUN;
          next_we    = i_ext_we;
          next_addr  = i_ext_addr;
          next_wdata = i_ext_wdata;
        end
      EMP_RUN:
      begin
        if (t_sample && !we)
          next_rdata = din_q;
        if (i_ext_bus_disable)
          next_state = EMP_IDLE;
        else if (t_last)
          next_state = EMP_DONE;
      end
      EMP_DONE:
        next_state = EMP_IDLE;
      default:
        next_state = EMP_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state <= EMP_IDLE;
      we    <= 1'b0;
      addr  <= EMP_ADDR_RESET;
      wdata <= '0;
      rdata <= '0;
    end
    else
    begin
      state <= next_state;
      we    <= next_we;
      addr  <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Pin outputs, registered.
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic data_oe;
  logic next_cs_n;
  logic next_rd_n;
  logic next_wr_n;
  logic next_data_oe;
  logic run_ok;

  assign run_ok = (state == EMP_RUN) && t_active && !i_ext_bus_disable;

  always_comb
  begin
    next_cs_n    = ~run_ok;
    next_rd_n    = ~(run_ok && !we && t_rd);
    next_wr_n    = ~(run_ok && we && t_wr);
    next_data_oe = run_ok && we;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cs_n    <= 1'b1;
      rd_n    <= 1'b1;
      wr_n    <= 1'b1;
      data_oe <= 1'b0;
    end
    else
    begin
      cs_n    <= next_cs_n;
      rd_n    <= next_rd_n;
      wr_n    <= next_wr_n;
      data_oe <= next_data_oe;
    end
  end

  assign o_memory_chip_select_n = cs_n;
  assign o_rd_n                 = rd_n;
  assign o_wr_n                 = wr_n;
  assign o_data_oe              = data_oe;
  assign o_addr                 = addr;
  assign o_data_out             = wdata;
  assign o_ext_rdata            = rdata;
  assign o_ext_busy             = (state != EMP_IDLE);
  assign o_ext_done             = (state == EMP_DONE);

endmodule : emp_port_ctrl

//--- test/emp_port_ctrl_properties.sv
// Checker of the external memory port controller: access timing and register reads.
// Assumes wait-control writes only between external accesses.
`timescale 1ns/1ps
module emp_port_ctrl_properties
(
  input wire logic        i_core_clk,
  input wire logic        i_rst_b,
  input wire logic        i_ext_bus_disable,
  input wire logic [15:0] i_io_addr,
  input wire logic        i_io_wr,
  input wire logic        i_io_rd,
  input wire logic [23:0] i_io_wdata,
  input wire logic [23:0] o_io_rdata,
  input wire logic        i_ext_we,
  input wire logic        o_ext_busy,
  input wire logic        o_ext_done,
  input wire logic        o_data_oe,
  input wire logic        o_memory_chip_select_n,
  input wire logic        o_rd_n,
  input wire logic        o_wr_n
);
  logic [4:0] wait_n;
  logic [4:0] next_wait_n;
  logic       busy_q;
  logic       we_q;
  logic       next_we_q;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [7:0] trail;
  logic [7:0] done_at;
  logic [7:0] rd_end;
  logic [7:0] wr_from;
  logic       in_acc;

  // =====
  // Mirror of the wait count and a cycle counter that reads 2 in the second busy cycle.
  always_comb
  begin
    next_wait_n = (i_io_wr && i_io_addr == 16'hFFFC) ? i_io_wdata[4:0] : wait_n;
    next_we_q   = (o_ext_busy && !busy_q) ? i_ext_we : we_q;
    next_cnt    = (o_ext_busy && !busy_q) ? 8'h02 : ((cnt == 8'hFF) ? cnt : cnt + 8'h01);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wait_n <= 5'h1F;
      busy_q <= 1'b0;
      we_q   <= 1'b0;
      cnt    <= 8'hFF;
    end
    else
    begin
      wait_n <= next_wait_n;
      busy_q <= o_ext_busy;
      we_q   <= next_we_q;
      cnt    <= next_cnt;
    end
  end

  assign trail   = (wait_n >= 5'h08) ? 8'h02 : ((wait_n >= 5'h04) ? 8'h01 : 8'h00);
  assign done_at = 8'h02 * (8'h01 + 8'(wait_n) + trail) + 8'h01;
  assign rd_end  = 8'h02 * (8'h01 + 8'(wait_n)) + 8'h01;
  assign wr_from = (wait_n <= 5'h01) ? 8'h03 : ((wait_n <= 5'h03) ? 8'h04 : 8'h05);
  assign in_acc  = o_ext_busy && busy_q;

  a_reset_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> o_memory_chip_select_n && o_rd_n && o_wr_n && !o_ext_busy)
    else $error("pins active right after reset");
  a_port_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_ext_bus_disable [*3] |-> o_memory_chip_select_n && o_rd_n && o_wr_n)
    else $error("strobe active while port disabled");
  a_done_time: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_ext_done |-> in_acc && cnt == done_at)
    else $error("access done at wrong cycle");
  a_done_late: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    in_acc && !i_ext_bus_disable && cnt == done_at |-> o_ext_done)
    else $error("access done missing");
  a_cs_span: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    in_acc && cnt <= done_at |-> !o_memory_chip_select_n)
    else $error("chip select released inside access");
  a_oe_span: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    in_acc && cnt <= done_at |-> o_data_oe == we_q)
    else $error("data enable wrong inside access");
  a_rd_window: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    in_acc && !we_q |-> o_rd_n == !(cnt >= 8'h03 && cnt <= rd_end))
    else $error("read strobe window wrong");
  a_wr_delay: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    in_acc && we_q |-> o_wr_n == !(cnt >= wr_from && cnt <= rd_end))
    else $error("write strobe window wrong");
  a_ctrl_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_io_rd && i_io_addr == 16'hFFFC |=> o_io_rdata == {19'h0, $past(wait_n)})
    else $error("wait control read wrong");
  a_high_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_io_rd && i_io_addr == 16'hFFF2 |=> o_io_rdata[23:8] == 16'h0)
    else $error("high half read not zero filled");
endmodule : emp_port_ctrl_properties

bind emp_port_ctrl emp_port_ctrl_properties u_props (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_ext_bus_disable(i_ext_bus_disable), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
  .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .i_ext_we(i_ext_we), .o_ext_busy(o_ext_busy),
  .o_ext_done(o_ext_done), .o_memory_chip_select_n(o_memory_chip_select_n), .o_rd_n(o_rd_n),
  .o_wr_n(o_wr_n), .o_data_oe(o_data_oe));

//--- test/emp_sram_model.sv
// Static memory model on the far side of the external port.
// Assumes one device, selected by chip select, decoding the low address byte.
`timescale 1ns/1ps
module emp_sram_model
(
  input  wire logic        i_core_clk,
  input  wire logic [15:0] i_addr,
  input  wire logic [23:0] i_data,
  input  wire logic        i_data_oe,
  input  wire logic        i_cs_n,
  input  wire logic        i_wr_n,
  output logic      [23:0] o_data
);
  logic [23:0] mem [0:255];
  logic [23:0] last = 24'h0;
  logic        drive;

  // Output enable follows chip select while i_data_oe is low; when released the bus shows the inverse of its last value.
  assign drive  = !i_cs_n && !i_data_oe;
  assign o_data = drive ? mem[i_addr[7:0]] : ~last;

  always @(posedge i_core_clk)
  begin
    if (drive)
      last <= mem[i_addr[7:0]];
    if (!i_cs_n && !i_wr_n)
      mem[i_addr[7:0]] <= i_data;
  end
endmodule : emp_sram_model

//--- test/testbench.sv
// Self-checking testbench of the external memory port controller.
// Assumes the memory model and the bound checker are compiled with it.
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        dis = 1'b0;
  logic [15:0] io_addr = 16'h0;
  logic        io_wr = 1'b0;
  logic        io_rd = 1'b0;
  logic        io_wide = 1'b0;
  logic [23:0] io_wdata = 24'h0;
  logic [23:0] io_rdata;
  logic        ext_req = 1'b0;
  logic        ext_we = 1'b0;
  logic [15:0] ext_addr = 16'h0;
  logic [23:0] ext_wdata = 24'h0;
  logic        busy, done, oe, cs_n, rd_n, wr_n, clk_out;
  logic [23:0] ext_rdata, dout, din, r;
  logic [15:0] addr;
  int          bad_count = 0;
  int          check_count = 0;
  int          ns[7] = '{1, 2, 3, 4, 7, 8, 31};
  int          n, t, k, hit;

  always #2 clk = ~clk;

  emp_port_ctrl DUT (.i_core_clk(clk), .i_rst_b(rst_b), .i_ext_bus_disable(dis), .i_io_addr(io_addr),
    .i_io_wr(io_wr), .i_io_rd(io_rd), .i_io_wide(io_wide), .i_io_wdata(io_wdata), .o_io_rdata(io_rdata),
    .i_ext_req(ext_req), .i_ext_we(ext_we), .i_ext_addr(ext_addr), .i_ext_wdata(ext_wdata),
    .o_ext_busy(busy), .o_ext_done(done), .o_ext_rdata(ext_rdata), .o_clock_out(clk_out), .o_addr(addr),
    .o_data_out(dout), .o_data_oe(oe), .i_data_in(din), .o_memory_chip_select_n(cs_n), .o_rd_n(rd_n),
    .o_wr_n(wr_n));

  emp_sram_model u_mem (.i_core_clk(clk), .i_addr(addr), .i_data(dout), .i_data_oe(oe), .i_cs_n(cs_n),
    .i_wr_n(wr_n), .o_data(din));

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_op(input logic wr, input logic [15:0] a, input logic wide, input logic [23:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wide <= wide;
    io_wdata <= d;
    io_wr <= wr;
    io_rd <= !wr;
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1 r = io_rdata;
  endtask : reg_op

  task automatic ext(input logic we, input logic [15:0] a, input logic [23:0] d, input int cyc);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    ext_req <= 1'b1;
    ext_we <= we;
    ext_addr <= a;
    ext_wdata <= d;
    for (k = 1; k < 90; k++)
    begin
      @(posedge clk);
      if (seen)
        ext_req <= 1'b0;
      #1;
      seen = seen | (busy === 1'b1);
      if (done === 1'b1)
        break;
    end
    check("done cycle", 24'(k), 24'(cyc));
    if (!we)
      check("read data", ext_rdata, d);
  endtask : ext

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check("chip select", 24'(cs_n), 24'h1);
    check("address", 24'(addr), 24'h00FFFF);
    check("clock out idle", 24'(clk_out), 24'h1);
    @(posedge clk);
    #1;
    check("clock out toggles", 24'(clk_out), 24'h0);
    reg_op(0, 16'hFFFC, 0, 0);
    check("wait reset", r, 24'h00001F);
    reg_op(0, 16'hFFF0, 0, 0);
    check("unmapped", r, 24'h0);
    reg_op(1, 16'hFFFC, 0, 24'h00FFE2);
    reg_op(0, 16'hFFFC, 0, 0);
    check("wait reserved", r, 24'h000002);
    $display("test control register done");
    reg_op(1, 16'hFFF4, 1, 24'hABCDEF);
    reg_op(0, 16'hFFF2, 1, 0);
    check("high wide", r, 24'h0000AB);
    reg_op(0, 16'hFFF2, 0, 0);
    check("high narrow", r, 24'h0000AB);
    reg_op(0, 16'hFFF3, 0, 0);
    check("low half", r, 24'h00CDEF);
    reg_op(0, 16'hFFF4, 0, 0);
    check("full narrow", r, 24'h00CDEF);
    reg_op(1, 16'hFFF4, 0, 24'h771234);
    reg_op(0, 16'hFFF4, 1, 0);
    check("full widened", r, 24'hAB1234);
    reg_op(1, 16'hFFF2, 0, 24'h00FF5A);
    reg_op(0, 16'hFFF2, 0, 0);
    check("high reserved", r, 24'h00005A);
    reg_op(0, 16'hFFF4, 1, 0);
    check("full wide", r, 24'h5A1234);
    $display("test holding register done");
    // Zero wait states are never programmed.
    foreach (ns[i])
    begin
      n = ns[i];
      t = (n >= 8) ? 2 : ((n >= 4) ? 1 : 0);
      reg_op(1, 16'hFFFC, 0, 24'(n));
      ext(1, 16'h0100 + 16'(n), {8'hA5, 8'(n), 8'h3C}, 2 * (1 + n + t) + 1);
      ext(0, 16'h0100 + 16'(n), {8'hA5, 8'(n), 8'h3C}, 2 * (1 + n + t) + 1);
    end
    $display("test access timing done");
    @(posedge clk);
    dis <= 1'b1;
    repeat (3) @(posedge clk);
    ext_req <= 1'b1;
    ext_we <= 1'b1;
    ext_addr <= 16'h0042;
    hit = 0;
    for (k = 0; k < 8; k++)
    begin
      @(posedge clk);
      #1;
      if (busy !== 1'b0 || cs_n !== 1'b1 || wr_n !== 1'b1 || addr !== 16'h011F)
        hit++;
    end
    check("port off", 24'(hit), 24'h0);
    @(posedge clk);
    ext_req <= 1'b0;
    dis <= 1'b0;
    ext(0, 16'h011F, 24'hA51F3C, 69);
    $display("test port disable done");
    summarize();
  end
endmodule : testbench
